// [prt_pkg.sv]
/*
  Constants shared by the process register and translation block:
  register offsets, control word fields, ALU operations and timing.
  Assumes a 10 MHz pclk and a 32-bit APB register bus.
*/
package prt_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FLOOR = 8'h04;
  localparam logic [7:0] OFF_CEIL = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_PRIM = 8'h10;
  localparam logic [7:0] OFF_STACK = 8'h14;
  localparam logic [7:0] OFF_OFFS = 8'h18;
  localparam logic [7:0] OFF_ALU = 8'h1C;
  localparam logic [7:0] OFF_QUEUE = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  localparam logic [7:0] OFF_PCINC = 8'h28;
  localparam logic [7:0] OFF_ARRAY = 8'h2C;
  // ----------------------------------------------------------------
  // Control word fields and reset value
  // ----------------------------------------------------------------
  localparam int CW_KERNEL = 0;
  localparam int CW_SUPER = 1;
  localparam int CW_INHIBIT = 2;
  localparam int CW_REFRESH = 3;
  localparam int CW_PTRAP = 4;
  localparam int CW_STACKCHK = 5;
  localparam int CW_DEBUG = 6;
  localparam int CW_NOTRAP = 7;
  localparam int CW_UCODE_LSB = 8;
  localparam int CW_RATE_LSB = 12;
  localparam logic [15:0] CW_RESET = 16'h0002;
  // ----------------------------------------------------------------
  // ALU operation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ALU_SHL = 4'h0;
  localparam logic [3:0] ALU_SHR = 4'h1;
  localparam logic [3:0] ALU_LIM = 4'h2;
  localparam logic [3:0] ALU_ADD = 4'h3;
  localparam logic [3:0] ALU_SUB = 4'h4;
  localparam logic [3:0] ALU_BADD = 4'h5;
  localparam logic [3:0] ALU_BSUB = 4'h6;
  localparam logic [3:0] ALU_AND = 4'h7;
  localparam logic [3:0] ALU_OR = 4'h8;
  localparam logic [3:0] ALU_XOR = 4'h9;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int REFRESH_STEP_NS = 250000;
  localparam int REFRESH_STEP_CYC = REFRESH_STEP_NS / CLK_NS;
endpackage

// [prt_alu.sv]
/*
  Single-cycle 8-bit ALU with ripple carry: shifts, limit compare,
  binary and packed BCD add/subtract, AND, OR, XOR.
  Assumes operands are stable for the whole cycle; purely combinational.
*/
module prt_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic [3:0] op,
  output logic [7:0] y,
  output logic cout
);
  import prt_pkg::*;
  logic [7:0] bx, g, p, sum;
  logic [8:0] c;
  logic sub;
  logic [4:0] lo, hi;

  // ----------------------------------------------------------------
  // Carry network
  // ----------------------------------------------------------------
  assign sub = (op == ALU_SUB) || (op == ALU_LIM) || (op == ALU_BSUB);
  assign bx = sub ? ~b : b;
  assign g = a & bx;
  assign p = a ^ bx;
  assign c[0] = sub ? 1'b1 : cin;
  // Carry ripples bit to bit; every carry still resolves in one cycle
  for (genvar i = 0; i < 8; i++) begin : g_cla
    assign c[i+1] = g[i] | (p[i] & c[i]);
  end
  assign sum = p ^ c[7:0];

  always_comb begin
    lo = 5'h00;
    hi = 5'h00;
    y = 8'h00;
    cout = 1'b0;
    case (op)
      ALU_SHL: begin
        y = {a[6:0], cin};
        cout = a[7];
      end
      ALU_SHR: begin
        y = {cin, a[7:1]};
        cout = a[0];
      end
      ALU_LIM: begin
        cout = ~c[8]; // Set when a is below b
        y = a;
      end
      ALU_ADD, ALU_SUB: begin
        y = sum;
        cout = c[8];
      end
      ALU_BADD: begin
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        if (lo > 5'h09) begin
          lo = lo + 5'h06;
        end
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09) begin
          hi = hi + 5'h06;
        end
        y = {hi[3:0], lo[3:0]};
        cout = hi[4];
      end
      ALU_BSUB: begin
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        if (lo[4]) begin
          lo = lo - 5'h06;
        end
        hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
        if (hi[4]) begin
          hi = hi - 5'h06;
        end
        y = {hi[3:0], lo[3:0]};
        cout = hi[4];
      end
      ALU_AND: y = a & b;
      ALU_OR: y = a | b;
      ALU_XOR: y = a ^ b;
      default: y = a;
    endcase
  end
endmodule

// [prt_queue.sv]
/*
  Input byte queue: fetched bytes wait here until control logic takes them.
  Assumes the owner never pushes when full nor pops when empty.
*/
module prt_queue #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic [$clog2(DEPTH):0] count
);
  import prt_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } prt_q_t;
  prt_q_t s, next_s;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = din;
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign dout = s.mem[s.rd];
  assign count = s.cnt;

  a_queue_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !push && !pop) |=> (count == $past(count) && dout == $past(dout)))
    else $error("queue byte lost without a pop");
endmodule

// [prt_regs.sv]
/*
  Process register set with APB access: floor and ceiling pages, program
  counter, data and stack pointers held as physical addresses, control word,
  offset addressing, ALU with a two-read one-write byte array, input queue,
  and refresh, periodic trap and interrupt entry.
  Assumes an APB master on pclk and synchronous pin inputs.
*/
// Local design decisions: the register addresses and the APB interface to the registers.
// Functional notes
// - 8-bit ALU uses look-ahead carry, every operation completes in one cycle; the code ripples the carry bit to bit.
// - ALU does shifts, limit check, binary and BCD add/sub, AND, OR, XOR.
// - Separate 8-bit incrementer advances program counter and refresh register; the code carries into the PC high byte with a plain adder.
// - Register array gives two reads and one write in each cycle.
// - Fetched bytes wait in the input queue until consumed.
// - Pointers held physical; reading out subtracts floor page base.
// - Loading a pointer adds the floor page base to the logical value.
// - Lowest process address is floor page with low byte zero.
// - Highest process address is ceiling page with low byte all ones.
// - Ceiling page is where process vectors and control data live.
// - Offset addressing adds the offset to the primary data pointer.
// - Stack top pointer may serve as the offset base likewise.
// - Control word bits: 0 kernel, 1 supervisor, 2 interrupt inhibit.
// - Control word bits: 3 refresh enable, 4 periodic trap, 6 debug.
// - Low interrupt pin starts entry after instruction if not inhibited.
// - Refresh happens only with refresh enable set, at counter rate.
// - Periodic trap fires on each refresh rollover when bit 4 is set and bit 7 is clear.
module prt_regs #(
  parameter int REFRESH_STEP = prt_pkg::REFRESH_STEP_CYC,
  parameter int QDEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_n,
  input wire logic instr_done,
  input wire logic irq_ack,
  output logic irq_start,
  output logic trap_req,
  output logic refresh_req,
  output logic [7:0] refresh_addr,
  output logic [3:0] ucode_sel,
  output logic kernel,
  output logic supervisor
);
  import prt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_ENTRY = 2'b10
  } prt_st_t;

  typedef struct packed {
    prt_st_t st;
    logic [15:0] ctrl;
    logic [15:0] floor;
    logic [15:0] ceil;
    logic [23:0] pc;
    logic [23:0] prim;
    logic [23:0] stack;
    logic [23:0] oaddr;
    logic fault;
    logic [7:0][7:0] rf;
    logic [7:0] alu_y;
    logic alu_c;
    logic [7:0] rfsh;
    logic [15:0] rcnt;
    logic [31:0] rdata;
    logic slverr;
    logic irq;
    logic trap;
    logic rreq;
  } prt_s_t;
  prt_s_t s, next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] to_phys(input logic [23:0] v, input logic [15:0] pg);
    to_phys = v + {pg, 8'h00};
  endfunction

  function automatic logic [23:0] to_log(input logic [23:0] v, input logic [15:0] pg);
    to_log = v - {pg, 8'h00};
  endfunction

  function automatic logic [8:0] inc8(input logic [7:0] v, input logic ci);
    inc8 = {1'b0, v} + {8'h00, ci};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFF_ARRAY);
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup, acc, wr, rd;
  assign setup = psel && !penable;
  assign acc = psel && penable && ce;
  assign wr = acc && pwrite && mapped(paddr);
  assign rd = acc && !pwrite && mapped(paddr);

  // ----------------------------------------------------------------
  // ALU and array ports
  // ----------------------------------------------------------------
  logic [2:0] ra, rb, rw;
  logic [7:0] alu_a, alu_b, alu_y;
  logic alu_cout;
  assign ra = pwdata[6:4];
  assign rb = pwdata[10:8];
  assign rw = pwdata[14:12];
  assign alu_a = s.rf[ra];
  assign alu_b = s.rf[rb];

  prt_alu u_alu (
    .a(alu_a),
    .b(alu_b),
    .cin(pwdata[16]),
    .op(pwdata[3:0]),
    .y(alu_y),
    .cout(alu_cout)
  );

  logic q_push, q_pop;
  logic [7:0] q_dout;
  logic [$clog2(QDEPTH):0] q_count;
  assign q_push = wr && (paddr == OFF_QUEUE) && (q_count != QDEPTH[$clog2(QDEPTH):0]);
  assign q_pop = rd && (paddr == OFF_QUEUE) && (q_count != '0);

  prt_queue #(.W(8), .DEPTH(QDEPTH)) u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .push(q_push),
    .din(pwdata[7:0]),
    .pop(q_pop),
    .dout(q_dout),
    .count(q_count)
  );

  // ----------------------------------------------------------------
  // Offset addressing and window check
  // ----------------------------------------------------------------
  logic [23:0] obase, oaddr;
  logic [23:0] lo_lim, hi_lim;
  assign obase = pwdata[16] ? s.stack : s.prim;
  assign oaddr = obase + {8'h00, pwdata[15:0]};
  assign lo_lim = {s.floor, 8'h00};
  assign hi_lim = {s.ceil, 8'hFF};

  logic roll;
  logic [15:0] reload;
  logic [31:0] rsel;
  logic [8:0] pcl, pcm, rfi;
  assign roll = (s.rcnt == 16'h0000);
  assign reload = 16'((32'(s.ctrl[CW_RATE_LSB +: 4]) + 32'd1) * REFRESH_STEP - 1);
  assign pcl = inc8(s.pc[7:0], 1'b1);
  assign pcm = inc8(s.pc[15:8], pcl[8]);
  assign rfi = inc8(s.rfsh, 1'b1);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rsel = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: rsel = {16'h0000, s.ctrl};
      OFF_FLOOR: rsel = {16'h0000, s.floor};
      OFF_CEIL: rsel = {16'h0000, 16'(s.ceil - s.floor)};
      OFF_PC: rsel = {8'h00, to_log(s.pc, s.floor)};
      OFF_PRIM: rsel = {8'h00, to_log(s.prim, s.floor)};
      OFF_STACK: rsel = {8'h00, to_log(s.stack, s.floor)};
      OFF_OFFS: rsel = {7'h00, s.fault, s.oaddr};
      OFF_ALU: rsel = {23'h000000, s.alu_c, s.alu_y};
      OFF_QUEUE: rsel = {24'h000000, q_dout};
      OFF_STAT: rsel = {16'h0000, s.rfsh, 3'h0, s.st == ST_ENTRY, 4'(q_count)};
      OFF_ARRAY: rsel = {s.rf[3], s.rf[2], s.rf[1], s.rf[0]};
      default: rsel = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.irq = 1'b0;
    next_s.trap = 1'b0;
    next_s.rreq = 1'b0;
    if (setup) begin
      next_s.rdata = rsel;
      next_s.slverr = !mapped(paddr);
    end
    if (wr) begin
      case (paddr)
        OFF_CTRL: next_s.ctrl = pwdata[15:0];
        OFF_FLOOR: next_s.floor = pwdata[15:0];
        OFF_CEIL: next_s.ceil = pwdata[15:0] + s.floor;
        OFF_PC: next_s.pc = to_phys(pwdata[23:0], s.floor);
        OFF_PRIM: next_s.prim = to_phys(pwdata[23:0], s.floor);
        OFF_STACK: next_s.stack = to_phys(pwdata[23:0], s.floor);
        OFF_OFFS: begin
          next_s.oaddr = oaddr;
          next_s.fault = (oaddr < lo_lim) || (oaddr > hi_lim);
        end
        OFF_ALU: begin
          next_s.rf[rw] = alu_y;
          next_s.alu_y = alu_y;
          next_s.alu_c = alu_cout;
        end
        OFF_PCINC: begin
          // High byte takes the carry through a plain adder, not the incrementer
          next_s.pc = {s.pc[23:16] + {7'h00, pcm[8]}, pcm[7:0], pcl[7:0]};
        end
        OFF_ARRAY: next_s.rf[pwdata[10:8]] = pwdata[7:0];
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    // Rollover runs regardless of refresh enable so the trap keeps its rate
    if (roll) begin
      next_s.rcnt = reload;
      next_s.rreq = s.ctrl[CW_REFRESH];
      next_s.trap = s.ctrl[CW_PTRAP] && !s.ctrl[CW_NOTRAP];
      if (s.ctrl[CW_REFRESH]) begin
        next_s.rfsh = rfi[7:0];
      end
    end else begin
      next_s.rcnt = s.rcnt - 16'h0001;
    end
    case (s.st)
      ST_RUN: begin
        if (!int_n && instr_done && !s.ctrl[CW_INHIBIT]) begin
          next_s.st = ST_ENTRY;
          next_s.irq = 1'b1;
        end
      end
      ST_ENTRY: begin
        if (irq_ack) begin
          next_s.st = ST_RUN;
        end
      end
      default: next_s.st = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= ST_RUN;
      s.ctrl <= CW_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s.rdata;
  assign pready = psel && penable && ce;
  assign pslverr = pready && s.slverr;
  assign irq_start = s.irq;
  assign trap_req = s.trap;
  assign refresh_req = s.rreq;
  assign refresh_addr = s.rfsh;
  assign ucode_sel = s.ctrl[CW_UCODE_LSB +: 4];
  assign kernel = s.ctrl[CW_KERNEL];
  assign supervisor = s.ctrl[CW_SUPER];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_irq_cause;
    ce && s.st == ST_RUN && !int_n && instr_done && !s.ctrl[CW_INHIBIT];
  endsequence

  a_irq_entry: assert property (@(posedge pclk) disable iff (!presetn)
    seq_irq_cause |=> (irq_start && s.st == ST_ENTRY))
    else $error("interrupt entry missed");

  a_irq_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_start && $past(ce)) |-> ($past(int_n) == 1'b0 && $past(s.ctrl[CW_INHIBIT]) == 1'b0))
    else $error("interrupt entered while inhibited");

  a_refresh_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (refresh_req && $past(ce)) |-> ($past(s.ctrl[CW_REFRESH]) && $past(s.rcnt) == 16'h0000))
    else $error("refresh without enable or rollover");

  a_trap_roll: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && roll && s.ctrl[CW_PTRAP] && !s.ctrl[CW_NOTRAP]) |=> trap_req)
    else $error("periodic trap missed");

  a_pc_load: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_PC) |=> s.pc == 24'($past(pwdata[23:0]) + {$past(s.floor), 8'h00}))
    else $error("program counter load not relocated");

  a_pc_store: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && setup && !pwrite && paddr == OFF_PC) |=>
      prdata[23:0] == 24'($past(s.pc) - {$past(s.floor), 8'h00}))
    else $error("program counter read not logical");

  a_offset_add: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_OFFS && !pwdata[16]) |=>
      s.oaddr == 24'($past(s.prim) + {8'h00, $past(pwdata[15:0])}))
    else $error("offset address wrong");

  a_alu_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_ALU) |=> s.rf[$past(rw)] == $past(alu_y))
    else $error("ALU result not written back");

  a_pc_step: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFF_PCINC) |=> s.pc == 24'($past(s.pc) + 24'h000001))
    else $error("program counter step wrong");
endmodule

// [prt_regs_tb.sv]
/*
  Self-checking bench for prt_regs: APB access to the control word, pages,
  pointers, offset addressing, ALU, queue, interrupt entry and refresh.
  Assumes prt_pkg is compiled first; ce is held high except in the freeze check.
*/
module prt_regs_tb;
  import prt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------
  localparam int STEP = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic int_n = 1'b1;
  logic instr_done = 1'b0;
  logic irq_ack = 1'b0;
  logic irq_start, trap_req, refresh_req, kernel, supervisor;
  logic [7:0] refresh_addr;
  logic [3:0] ucode_sel;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] rv;
  logic ev;
  `define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

  always #50 pclk = ~pclk;

  prt_regs #(.REFRESH_STEP(STEP), .QDEPTH(4)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_n(int_n),
    .instr_done(instr_done), .irq_ack(irq_ack), .irq_start(irq_start), .trap_req(trap_req),
    .refresh_req(refresh_req), .refresh_addr(refresh_addr), .ucode_sel(ucode_sel),
    .kernel(kernel), .supervisor(supervisor));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Idle edge first so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, ev);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000, rv, ev);
  endtask

  task automatic cycles(input int n, output int nref, output int ntrap, output int nirq);
    nref = 0;
    ntrap = 0;
    nirq = 0;
    repeat (n) begin
      @(posedge pclk);
      nref += int'(refresh_req === 1'b1);
      ntrap += int'(trap_req === 1'b1);
      nirq += int'(irq_start === 1'b1);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ctrl();
    `CHK(supervisor, 1'b1)
    `CHK(kernel, 1'b0)
    rd(OFF_CTRL);
    `CHK(rv[15:0], CW_RESET)
    wr(OFF_CTRL, 32'h0000_0069);
    rd(OFF_CTRL);
    `CHK(rv[6:0], 7'h69)
    `CHK({kernel, supervisor}, 2'b10)
    wr(OFF_CTRL, 32'h0000_0516);
    rd(OFF_CTRL);
    `CHK(rv[6:0], 7'h16)
    `CHK(ucode_sel, 4'h5)
    `CHK({kernel, supervisor}, 2'b01)
    wr(OFF_CTRL, 32'h0000_0000);
    rd(8'h30);
    `CHK({ev, rv}, {1'b1, 32'h0000_0000})
    apb(1'b1, 8'h05, 32'hFFFF_FFFF, rv, ev);
    `CHK(ev, 1'b1)
  endtask

  task automatic t_pages();
    wr(OFF_FLOOR, 32'h0000_04E7);
    wr(OFF_CEIL, 32'h0000_0010);
    wr(OFF_PRIM, 32'h0000_0010);
    rd(OFF_PRIM);
    `CHK(rv[23:0], 24'h000010)
    wr(OFF_OFFS, 32'h0000_0005);
    rd(OFF_OFFS);
    `CHK(rv[24:0], {1'b0, 24'h04E715})
    wr(OFF_STACK, 32'h0000_0100);
    wr(OFF_OFFS, 32'h0001_0020);
    rd(OFF_OFFS);
    `CHK(rv[24:0], {1'b0, 24'h04E820})
    rd(OFF_STACK);
    `CHK(rv[23:0], 24'h000100)
    rd(OFF_CEIL);
    `CHK(rv[15:0], 16'h0010)
    wr(OFF_PRIM, 32'h0000_0000);
    wr(OFF_OFFS, 32'h0000_0000);
    rd(OFF_OFFS);
    `CHK(rv[24:0], {1'b0, 24'h04E700})
    wr(OFF_PRIM, 32'h0000_1000);
    wr(OFF_OFFS, 32'h0000_00FF);
    rd(OFF_OFFS);
    `CHK(rv[24:0], {1'b0, 24'h04F7FF})
    wr(OFF_OFFS, 32'h0000_0100);
    rd(OFF_OFFS);
    `CHK(rv[24:0], {1'b1, 24'h04F800})
    wr(OFF_PC, 32'h0000_00FF);
    wr(OFF_PCINC, 32'h0000_0000);
    rd(OFF_PC);
    `CHK(rv[23:0], 24'h000100)
  endtask

  task automatic t_alu();
    logic [3:0] ops [10] = '{ALU_SHL, ALU_SHR, ALU_LIM, ALU_ADD, ALU_SUB, ALU_BADD, ALU_BSUB,
                             ALU_AND, ALU_OR, ALU_XOR};
    logic [7:0] exp [10] = '{8'h8A, 8'h22, 8'h45, 8'h7D, 8'h0D, 8'h83, 8'h07, 8'h00, 8'h7D, 8'h7D};
    wr(OFF_ARRAY, 32'h0000_0045);
    wr(OFF_ARRAY, 32'h0000_0138);
    for (int i = 0; i < 10; i++) begin
      wr(OFF_ALU, 32'h0000_2100 | 32'(ops[i]));
      rd(OFF_ALU);
      `CHK(rv[7:0], exp[i])
    end
    rd(OFF_ARRAY);
    `CHK(rv[23:0], 24'h7D3845)
    wr(OFF_ALU, 32'h0001_2100 | 32'(ALU_ADD));
    rd(OFF_ALU);
    `CHK(rv[8:0], 9'h07E)
    wr(OFF_ALU, 32'h0000_2010 | 32'(ALU_LIM));
    rd(OFF_ALU);
    `CHK(rv[8:0], 9'h138)
    wr(OFF_ALU, 32'h0000_3220 | 32'(ALU_BADD));
    rd(OFF_ARRAY);
    `CHK(rv[31:24], 8'h76)
  endtask

  task automatic t_queue();
    for (int i = 0; i < 5; i++) wr(OFF_QUEUE, 32'(8'hA0 + i));
    rd(OFF_STAT);
    `CHK(rv[3:0], 4'h4)
    for (int i = 0; i < 4; i++) begin
      rd(OFF_QUEUE);
      `CHK(rv[7:0], 8'(8'hA0 + i))
    end
    rd(OFF_STAT);
    `CHK(rv[3:0], 4'h0)
  endtask

  task automatic t_irq();
    int nr, nt, ni;
    int_n <= 1'b0;
    cycles(10, nr, nt, ni);
    `CHK(ni, 0)
    wr(OFF_CTRL, 32'h0000_0004);
    instr_done <= 1'b1;
    cycles(10, nr, nt, ni);
    `CHK(ni, 0)
    wr(OFF_CTRL, 32'h0000_0000);
    cycles(6, nr, nt, ni);
    `CHK(ni, 1)
    rd(OFF_STAT);
    `CHK(rv[4], 1'b1)
    int_n <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    instr_done <= 1'b0;
    rd(OFF_STAT);
    `CHK(rv[4], 1'b0)
  endtask

  task automatic t_refresh();
    int nr, nt, ni;
    logic [7:0] ra;
    wr(OFF_CTRL, 32'h0000_0008);
    // Skip the edge that still rolls under the old control word
    repeat (2) @(posedge pclk);
    ra = refresh_addr;
    cycles(40, nr, nt, ni);
    `CHK(nr, 10)
    `CHK(nt, 0)
    `CHK(refresh_addr, 8'(ra + 8'h0A))
    wr(OFF_CTRL, 32'h0000_1010);
    repeat (2) @(posedge pclk);
    ra = refresh_addr;
    cycles(40, nr, nt, ni);
    `CHK(nt, 5)
    `CHK(nr, 0)
    `CHK(refresh_addr, ra)
    wr(OFF_CTRL, 32'h0000_0090);
    @(posedge pclk);
    cycles(40, nr, nt, ni);
    `CHK(nt, 0)
    // Clock enable low must freeze the refresh counter and row
    wr(OFF_CTRL, 32'h0000_0008);
    ce <= 1'b0;
    @(posedge pclk);
    ra = refresh_addr;
    cycles(20, nr, nt, ni);
    `CHK(nr, 0)
    `CHK(refresh_addr, ra)
    ce <= 1'b1;
    wr(OFF_CTRL, 32'h0000_0000);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_ctrl();
    t_pages();
    t_alu();
    t_queue();
    t_irq();
    t_refresh();
    conclude();
  end
endmodule
